// ### rtl/mmdec_top.sv
// memory map address decoder with per-master routing and single ram arbitration
`timescale 1ns/10ps
module mmdec_top import mmdec_pkg::*; #(
	parameter int NM = MMDEC_NUM_MST
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// rom disable bit write from software (status register 3)
	input wire logic rom_disable_wr,
	input wire logic rom_disable_val,
	input wire logic soft_reset,
	// master requests, index 0 cpu, 1..4 dma, 5 lcd, 6 usb
	input wire logic [NM-1:0] req_valid,
	input wire logic [NM-1:0] req_write,
	input wire logic [NM-1:0] req_io,
	input wire logic [NM*32-1:0] req_addr,
	// decoded results, registered
	output logic [NM-1:0] grant_r,
	output logic [NM-1:0] unmapped_r,
	output logic [NM-1:0] refused_r,
	output logic [NM*8-1:0] target_r,
	output logic [NM*6-1:0] block_r,
	output logic [NM*24-1:0] local_addr_r,
	output logic [NM-1:0] write_en_r,
	// external chip selects, active low
	output logic [MMDEC_NUM_EXT-1:0] external_chip_select_n_r,
	output logic sdram_pair_n_r,
	// rom disable bit state
	output logic rom_disable_bit_r,
	// sdram select mode: 0 first select only, 1 first and second
	input wire logic sdram_dual_cs
);
	// ------------------------------------------------------------
	// decode function
	// ------------------------------------------------------------
	// maps a cpu-view address onto a target class, rom gated by the disable bit
	function automatic mmdec_tgt_t mmdec_class(input logic [23:0] a, input logic romdis);
		mmdec_tgt_t t;
		t = MMDEC_T_NONE;
		if (a < MMDEC_REG_END) begin
			t = MMDEC_T_REGS;
		end else if (a < MMDEC_SINGLE_ACCESS_RAM_BASE) begin
			t = MMDEC_T_DUAL_ACCESS_RAM;
		end else if (a < MMDEC_EXT0_BASE) begin
			t = MMDEC_T_SINGLE_ACCESS_RAM;
		end else if (a < MMDEC_ROM_BASE) begin
			t = MMDEC_T_EXT;
		end else if (!romdis) begin
			t = MMDEC_T_ROM;
		end else begin
			t = MMDEC_T_NONE;
		end
		return t;
	endfunction

	// external space index of a cpu-view address
	function automatic logic [2:0] mmdec_ext_idx(input logic [23:0] a);
		logic [2:0] i;
		i = 3'h0;
		if (a >= MMDEC_EXT5_BASE) begin
			i = 3'h4;
		end else if (a >= MMDEC_EXT4_BASE) begin
			i = 3'h3;
		end else if (a >= MMDEC_EXT3_BASE) begin
			i = 3'h2;
		end else if (a >= MMDEC_EXT2_BASE) begin
			i = 3'h1;
		end
		return i;
	endfunction

	// io windows reachable by dma
	function automatic logic mmdec_io_dma_ok(input logic [15:0] a);
		return (a >= MMDEC_IO_EXTERNAL_MEMORY_INTERFACE_LO && a <= MMDEC_IO_EXTERNAL_MEMORY_INTERFACE_HI) ||
			(a >= MMDEC_IO_I2C_LO && a <= MMDEC_IO_I2C_HI) ||
			(a >= MMDEC_IO_UART_LO && a <= MMDEC_IO_UART_HI) ||
			(a >= MMDEC_IO_I2S_LO && a <= MMDEC_IO_I2S_HI) ||
			(a >= MMDEC_IO_CARD_LO && a <= MMDEC_IO_CARD_HI) ||
			(a >= MMDEC_IO_SAR_LO && a <= MMDEC_IO_SAR_HI) ||
			(a >= MMDEC_IO_USB_LO);
	endfunction

	// ------------------------------------------------------------
	// rom disable bit
	// ------------------------------------------------------------
	logic rom_disable_nxt; // next value of the rom disable bit
	// soft reset deliberately does not touch the bit
	assign rom_disable_nxt = rom_disable_wr ? rom_disable_val : rom_disable_bit_r;

	// hardware reset clears, software write sets or clears
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rom_disable_bit_r <= MMDEC_ROMDIS_RST;
		end else begin
			rom_disable_bit_r <= rom_disable_nxt;
		end
	end

	// ------------------------------------------------------------
	// per-master combinational decode
	// ------------------------------------------------------------
	logic [NM*24-1:0] cpu_addr; // address folded into cpu view
	logic [NM-1:0] view_ok; // address lies inside the master's view
	logic [NM*8-1:0] tgt; // target class per master
	logic [NM*6-1:0] blk; // block index per master
	logic [NM-1:0] refuse; // access refused by policy
	logic [NM-1:0] is_single_access_ram; // wants single ram
	logic [NM*5-1:0] sblk; // single ram block per master
	logic [NM*3-1:0] eidx; // external space per master

	genvar g;
	generate
		for (g = 0; g < NM; g++) begin : gen_dec
			logic [31:0] a32; // raw request address
			logic [31:0] rel; // offset into dma region
			logic [23:0] ca; // cpu-view address
			logic vok; // inside view
			mmdec_tgt_t tc; // decoded class
			logic dma_like; // master uses the dma view
			logic iook; // io target allowed
			assign a32 = req_addr[g*32 +: 32];
			assign dma_like = (g != MMDEC_M_CPU);
			// fold the dma view into cpu-view addresses
			assign rel = a32 - MMDEC_DMA_EXT_BASE;
			assign vok = !dma_like ? (a32[31:24] == 8'h00) :
				(a32 >= MMDEC_DMA_DUAL_ACCESS_RAM_BASE && a32 < MMDEC_DMA_END);
			assign ca = !dma_like ? a32[23:0] :
				(a32 < MMDEC_DMA_SINGLE_ACCESS_RAM_BASE) ? (a32[23:0] - MMDEC_DMA_DUAL_ACCESS_RAM_BASE[23:0]) :
				(a32 < MMDEC_DMA_EXT_BASE) ? (a32[23:0] - MMDEC_DMA_SINGLE_ACCESS_RAM_BASE[23:0] + MMDEC_SINGLE_ACCESS_RAM_BASE) :
				(a32 >= MMDEC_DMA_ROM_BASE) ? (a32[23:0] - MMDEC_DMA_ROM_BASE[23:0] + MMDEC_ROM_BASE) :
				(rel[27:24] == 4'h0) ? (MMDEC_EXT0_BASE + {1'h0, rel[22:0]}) :
				(rel[27:24] == 4'h1) ? (MMDEC_EXT2_BASE + {2'h0, rel[21:0]}) :
				(rel[27:24] == 4'h2) ? (MMDEC_EXT3_BASE + {3'h0, rel[20:0]}) :
				(rel[27:24] == 4'h3) ? (MMDEC_EXT4_BASE + {4'h0, rel[19:0]}) :
				(MMDEC_EXT5_BASE + {4'h0, rel[19:0]});
			// io space: cpu by io opcode, dma controllers by windows
			assign iook = (g == MMDEC_M_CPU) || ((g != MMDEC_M_LCD) && (g != MMDEC_M_USB) &&
				mmdec_io_dma_ok(a32[15:0]));
			assign tc = req_io[g] ? (iook ? MMDEC_T_IO : MMDEC_T_IOREF) :
				(vok ? mmdec_class(ca, rom_disable_bit_r) : MMDEC_T_NONE);
			assign cpu_addr[g*24 +: 24] = req_io[g] ? {8'h00, a32[15:0]} : ca;
			assign view_ok[g] = vok;
			assign tgt[g*8 +: 8] = tc;
			// usb and lcd are kept off dual ram and mapped registers
			assign refuse[g] = ((g == MMDEC_M_LCD) || (g == MMDEC_M_USB)) &&
				(tc == MMDEC_T_DUAL_ACCESS_RAM || tc == MMDEC_T_REGS);
			assign is_single_access_ram[g] = req_valid[g] && (tc == MMDEC_T_SINGLE_ACCESS_RAM) && !refuse[g];
			assign sblk[g*5 +: 5] = 5'(ca[23:MMDEC_BLK_SHIFT] - MMDEC_SINGLE_ACCESS_RAM_BASE[23:MMDEC_BLK_SHIFT]);
			assign eidx[g*3 +: 3] = mmdec_ext_idx(ca);
			assign blk[g*6 +: 6] = (tc == MMDEC_T_ROM) ? 6'(ca[16:MMDEC_ROM_SHIFT]) :
				(tc == MMDEC_T_EXT) ? {3'h0, mmdec_ext_idx(ca)} :
				(tc == MMDEC_T_SINGLE_ACCESS_RAM) ? {1'b0, sblk[g*5 +: 5]} :
				6'(ca[15:MMDEC_BLK_SHIFT]);
		end
	endgenerate

	// ------------------------------------------------------------
	// single ram collision arbitration
	// ------------------------------------------------------------
	// fixed priority, lowest master index wins a block; dual ram needs none
	logic [NM-1:0] sar_lose; // lost the block this cycle
	generate
		for (g = 0; g < NM; g++) begin : gen_arb
			logic [NM-1:0] hit; // higher-priority master on same block
			genvar h;
			for (h = 0; h < NM; h++) begin : gen_cmp
				if (h < g) begin : gen_lo
					assign hit[h] = is_single_access_ram[h] && (sblk[h*5 +: 5] == sblk[g*5 +: 5]);
				end else begin : gen_hi
					assign hit[h] = 1'b0;
				end
			end
			assign sar_lose[g] = is_single_access_ram[g] && (|hit);
		end
	endgenerate

	// ------------------------------------------------------------
	// grants and chip selects
	// ------------------------------------------------------------
	logic [NM-1:0] grant_nxt; // access accepted this cycle
	logic [NM-1:0] unmapped_nxt; // access hits nothing
	logic [MMDEC_NUM_EXT-1:0] cs_nxt; // active-high chip selects
	logic [NM-1:0] ext_pick; // external accepted per master

	generate
		for (g = 0; g < NM; g++) begin : gen_gnt
			// unmapped reads return zero and writes are dropped at the target
			assign unmapped_nxt[g] = req_valid[g] && (tgt[g*8 +: 8] == MMDEC_T_NONE ||
				tgt[g*8 +: 8] == MMDEC_T_IOREF);
			assign grant_nxt[g] = req_valid[g] && !unmapped_nxt[g] && !refuse[g] && !sar_lose[g];
			assign ext_pick[g] = grant_nxt[g] && (tgt[g*8 +: 8] == MMDEC_T_EXT);
		end
	endgenerate

	// one chip select, for the lowest-index master with an external access
	always_comb begin
		cs_nxt = '0;
		for (int i = NM - 1; i >= 0; i--) begin
			if (ext_pick[i]) begin
				cs_nxt = '0;
				cs_nxt[eidx[i*3 +: 3]] = 1'b1;
			end
		end
	end

	logic pair_nxt; // second select joins the first in dual mode
	assign pair_nxt = sdram_dual_cs && cs_nxt[0];

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	// all results captured on the clock so outputs come from flops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			grant_r <= '0;
			unmapped_r <= '0;
			refused_r <= '0;
			target_r <= '0;
			block_r <= '0;
			local_addr_r <= '0;
			write_en_r <= '0;
			external_chip_select_n_r <= '1;
			sdram_pair_n_r <= 1'b1;
		end else begin
			grant_r <= grant_nxt;
			unmapped_r <= unmapped_nxt;
			refused_r <= req_valid & (refuse | sar_lose);
			target_r <= tgt;
			block_r <= blk;
			local_addr_r <= cpu_addr;
			write_en_r <= grant_nxt & req_write;
			external_chip_select_n_r <= ~cs_nxt;
			sdram_pair_n_r <= ~pair_nxt;
		end
	end

	// soft reset and view flag are informational only
	logic unused_ok; // keeps intent visible
	assign unused_ok = soft_reset | (&view_ok);
endmodule

// ### rtl/mmdec_pkg.sv
// constants and types of the memory map address decoder
package mmdec_pkg;
	// ------------------------------------------------------------
	// Notes on behaviour
	// ------------------------------------------------------------

	// cpu view boundaries (byte addresses, 24 bits)
	localparam logic [23:0] MMDEC_REG_END = 24'h0000C0;
	localparam logic [23:0] MMDEC_SINGLE_ACCESS_RAM_BASE = 24'h010000;
	localparam logic [23:0] MMDEC_EXT0_BASE = 24'h050000;
	localparam logic [23:0] MMDEC_EXT2_BASE = 24'h800000;
	localparam logic [23:0] MMDEC_EXT3_BASE = 24'hC00000;
	localparam logic [23:0] MMDEC_EXT4_BASE = 24'hE00000;
	localparam logic [23:0] MMDEC_EXT5_BASE = 24'hF00000;
	localparam logic [23:0] MMDEC_ROM_BASE = 24'hFE0000;
	// dma view offsets (32-bit byte addresses)
	localparam logic [31:0] MMDEC_DMA_DUAL_ACCESS_RAM_BASE = 32'h0001_0000;
	localparam logic [31:0] MMDEC_DMA_SINGLE_ACCESS_RAM_BASE = 32'h0009_0000;
	localparam logic [31:0] MMDEC_DMA_EXT_BASE = 32'h0100_0000;
	localparam logic [31:0] MMDEC_DMA_EXT_STEP = 32'h0100_0000;
	localparam logic [31:0] MMDEC_DMA_ROM_BASE = 32'h050E_0000;
	localparam logic [31:0] MMDEC_DMA_END = 32'h0510_0000;
	// block geometry
	localparam int MMDEC_BLK_SHIFT = 13;
	localparam int MMDEC_ROM_SHIFT = 15;
	localparam int MMDEC_NUM_DUAL_ACCESS_RAM = 8;
	localparam int MMDEC_NUM_SINGLE_ACCESS_RAM = 32;
	localparam int MMDEC_NUM_ROM = 4;
	localparam int MMDEC_NUM_EXT = 5;
	localparam int MMDEC_NUM_MST = 7;
	// io space peripheral windows (word addresses)
	localparam logic [15:0] MMDEC_IO_EXTERNAL_MEMORY_INTERFACE_LO = 16'h1000;
	localparam logic [15:0] MMDEC_IO_EXTERNAL_MEMORY_INTERFACE_HI = 16'h10DD;
	localparam logic [15:0] MMDEC_IO_I2C_LO = 16'h1A00;
	localparam logic [15:0] MMDEC_IO_I2C_HI = 16'h1A6C;
	localparam logic [15:0] MMDEC_IO_UART_LO = 16'h1B00;
	localparam logic [15:0] MMDEC_IO_UART_HI = 16'h1B1F;
	localparam logic [15:0] MMDEC_IO_I2S_LO = 16'h2800;
	localparam logic [15:0] MMDEC_IO_I2S_HI = 16'h2B40;
	localparam logic [15:0] MMDEC_IO_CARD_LO = 16'h3A00;
	localparam logic [15:0] MMDEC_IO_CARD_HI = 16'h3B1F;
	localparam logic [15:0] MMDEC_IO_SAR_LO = 16'h7000;
	localparam logic [15:0] MMDEC_IO_SAR_HI = 16'h70FF;
	localparam logic [15:0] MMDEC_IO_USB_LO = 16'h8000;
	// reset value of the rom disable bit
	localparam logic MMDEC_ROMDIS_RST = 1'b0;
	// master indexes
	localparam int MMDEC_M_CPU = 0;
	localparam int MMDEC_M_LCD = 5;
	localparam int MMDEC_M_USB = 6;

	// target classes
	typedef enum logic [7:0] {
		MMDEC_T_NONE = 8'h01,
		MMDEC_T_REGS = 8'h02,
		MMDEC_T_DUAL_ACCESS_RAM = 8'h04,
		MMDEC_T_SINGLE_ACCESS_RAM = 8'h08,
		MMDEC_T_EXT = 8'h10,
		MMDEC_T_ROM = 8'h20,
		MMDEC_T_IO = 8'h40,
		MMDEC_T_IOREF = 8'h80
	} mmdec_tgt_t;
endpackage

// ### verif/mmdec_mst_model.sv
// bus master stand-in raising per-master requests toward the decoder
`timescale 1ns/10ps
module mmdec_mst_model import mmdec_pkg::*; #(
	parameter int NM = MMDEC_NUM_MST
) (
	// request lines toward the decoder
	output logic [NM-1:0] req_valid,
	output logic [NM-1:0] req_write,
	output logic [NM-1:0] req_io,
	output logic [NM*32-1:0] req_addr
);
	// all masters idle at time zero
	initial begin
		req_valid = '0;
		req_write = '0;
		req_io = '0;
		req_addr = '0;
	end
	// raise one master's request; address, write and io flag driven as given, unchecked
	task automatic put(input int i, input logic [31:0] a, input logic w, input logic io);
		req_addr[i*32+:32] = a;
		req_write[i] = w;
		req_io[i] = io;
		req_valid[i] = 1'b1;
	endtask
	// drop all requests; released address lines show the inverse of the last value
	task automatic clear();
		req_valid = '0;
		req_addr = ~req_addr;
	endtask
endmodule

// ### verif/mmdec_asserts.sv
// concurrent checks on the decoder's ports
`timescale 1ns/10ps
module mmdec_asserts import mmdec_pkg::*; #(
	parameter int NM = MMDEC_NUM_MST
) (
	// clock, reset and controls
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic rom_disable_wr,
	input wire logic rom_disable_val,
	input wire logic soft_reset,
	input wire logic sdram_dual_cs,
	// requests
	input wire logic [NM-1:0] req_valid,
	input wire logic [NM-1:0] req_write,
	input wire logic [NM-1:0] req_io,
	input wire logic [NM*32-1:0] req_addr,
	// results
	input wire logic [NM-1:0] grant_r,
	input wire logic [NM-1:0] unmapped_r,
	input wire logic [NM-1:0] refused_r,
	input wire logic [NM*8-1:0] target_r,
	input wire logic [NM*6-1:0] block_r,
	input wire logic [NM*24-1:0] local_addr_r,
	input wire logic [NM-1:0] write_en_r,
	input wire logic [MMDEC_NUM_EXT-1:0] external_chip_select_n_r,
	input wire logic sdram_pair_n_r,
	input wire logic rom_disable_bit_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// cpu memory request inside the 24-bit map
	wire cpu_mem = req_valid[0] && !req_io[0] && (req_addr[31:24] == 8'h00);
	wire [23:0] ca = req_addr[23:0];
	a_cpu_answered: assert property (req_valid[0] |=> grant_r[0] || unmapped_r[0] || refused_r[0])
		else $error("cpu request got no answer");
	a_target_onehot: assert property (grant_r[0] |-> $onehot(target_r[7:0]) && !unmapped_r[0])
		else $error("granted cpu access lacks a single target");
	a_rom_bit_write: assert property (rom_disable_wr |=> rom_disable_bit_r == $past(rom_disable_val))
		else $error("rom disable bit did not take written value");
	a_rom_bit_hold: assert property (!rom_disable_wr |=> $stable(rom_disable_bit_r))
		else $error("rom disable bit changed without a write");
	a_rom_mapped: assert property (cpu_mem && ca >= MMDEC_ROM_BASE && !rom_disable_bit_r && !rom_disable_wr
		|=> target_r[7:0] == MMDEC_T_ROM)
		else $error("rom range not routed to rom");
	a_rom_removed: assert property (cpu_mem && ca >= MMDEC_ROM_BASE && rom_disable_bit_r && !rom_disable_wr
		|=> unmapped_r[0] && !write_en_r[0])
		else $error("disabled rom range not unmapped");
	a_unmapped_write: assert property (write_en_r[0] |-> grant_r[0] && !unmapped_r[0])
		else $error("write strobe on unmapped access");
	a_sdram_select: assert property (cpu_mem && ca >= MMDEC_EXT0_BASE && ca < MMDEC_EXT2_BASE
		|=> external_chip_select_n_r == 5'h1E)
		else $error("first external select wrong");
	a_last_space: assert property (cpu_mem && ca >= MMDEC_EXT5_BASE && ca < MMDEC_ROM_BASE
		|=> external_chip_select_n_r == 5'h0F)
		else $error("last external select wrong");
	a_lcd_no_dual: assert property (req_valid[5] && !req_io[5] && req_addr[191:176] == 16'h0001
		|=> refused_r[5] && !grant_r[5])
		else $error("lcd reached dual ram");
	c_rom_hit: cover property (grant_r[0] && target_r[7:0] == MMDEC_T_ROM);
	c_lcd_refused: cover property (refused_r[5]);
	c_last_cs: cover property (!external_chip_select_n_r[4]);
endmodule
bind mmdec_top mmdec_asserts #(.NM(NM)) u_chk (.sys_clk, .rstn, .rom_disable_wr, .rom_disable_val,
	.soft_reset, .sdram_dual_cs, .req_valid, .req_write, .req_io, .req_addr, .grant_r, .unmapped_r,
	.refused_r, .target_r, .block_r, .local_addr_r, .write_en_r, .external_chip_select_n_r,
	.sdram_pair_n_r, .rom_disable_bit_r);

// ### verif/mmdec_top_tb.sv
// self-checking bench for the memory map address decoder
`timescale 1ns/10ps
module mmdec_top_tb import mmdec_pkg::*;;
	localparam int NM = MMDEC_NUM_MST;
	logic sys_clk, rstn, rom_disable_wr, rom_disable_val, soft_reset, sdram_dual_cs;
	logic [NM-1:0] req_valid, req_write, req_io, grant_r, unmapped_r, refused_r, write_en_r;
	logic [NM*32-1:0] req_addr;
	logic [NM*8-1:0] target_r;
	logic [NM*6-1:0] block_r;
	logic [NM*24-1:0] local_addr_r;
	logic [MMDEC_NUM_EXT-1:0] external_chip_select_n_r;
	logic sdram_pair_n_r, rom_disable_bit_r;
	int fail_count = 0;
	int cmp_count = 0;
	mmdec_mst_model #(.NM(NM)) mm (.req_valid, .req_write, .req_io, .req_addr);
	mmdec_top #(.NM(NM)) dut (.sys_clk, .rstn, .rom_disable_wr, .rom_disable_val, .soft_reset,
		.req_valid, .req_write, .req_io, .req_addr, .grant_r, .unmapped_r, .refused_r, .target_r,
		.block_r, .local_addr_r, .write_en_r, .external_chip_select_n_r, .sdram_pair_n_r,
		.rom_disable_bit_r, .sdram_dual_cs);
	// compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	// one edge to sample requests, then settle at the falling edge
	task automatic go();
		@(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	function automatic logic [7:0] tg(input int i);
		return target_r[i*8+:8];
	endfunction
	task automatic set_rom(input logic v);
		rom_disable_val = v;
		rom_disable_wr = 1'b1;
		go();
		rom_disable_wr = 1'b0;
	endtask
	// rom placement in both views
	task automatic t_rom();
		chk("rom_bit", 0, rom_disable_bit_r);
		mm.put(0, 32'h00FE0000, 0, 0);
		go();
		chk("rom_tgt", MMDEC_T_ROM, tg(0));
		chk("rom_blk", 0, block_r[5:0]);
		mm.put(0, 32'h00FFFFFF, 0, 0);
		mm.put(2, 32'h050E0000, 0, 0);
		go();
		chk("rom_blk_top", 3, block_r[5:0]);
		chk("dma_rom", MMDEC_T_ROM, tg(2));
		chk("dma_rom_addr", 32'h00FE0000, local_addr_r[71:48]);
		mm.clear();
	endtask
	// rom removal, software and hardware reset
	task automatic t_romdis();
		set_rom(1'b1);
		soft_reset = 1'b1;
		go();
		soft_reset = 1'b0;
		chk("rom_bit_soft", 1, rom_disable_bit_r);
		mm.put(0, 32'h00FE0000, 1, 0);
		go();
		chk("rom_off", 1, unmapped_r[0]);
		chk("rom_off_we", 0, write_en_r[0]);
		mm.clear();
		rstn = 1'b0;
		go();
		rstn = 1'b1;
		chk("rom_bit_hw", 0, rom_disable_bit_r);
	endtask
	// every external space at both ends, plus the ram edge below
	task automatic t_ext();
		logic [23:0] a[10] = '{24'h050000, 24'h7FFFFF, 24'h800000, 24'hBFFFFF, 24'hC00000,
			24'hDFFFFF, 24'hE00000, 24'hEFFFFF, 24'hF00000, 24'hFDFFFF};
		for (int k = 0; k < 10; k++) begin
			mm.put(0, {8'h00, a[k]}, 0, 0);
			go();
			chk("ext_tgt", MMDEC_T_EXT, tg(0));
			chk("ext_cs", 5'(~(5'h01 << (k / 2))), external_chip_select_n_r);
		end
		mm.put(0, 32'h0004FFFF, 0, 0);
		go();
		chk("single_access_ram_top", 31, block_r[5:0]);
		sdram_dual_cs = 1'b1;
		mm.put(0, 32'h00050000, 0, 0);
		go();
		chk("sdram_pair", 0, sdram_pair_n_r);
		sdram_dual_cs = 1'b0;
		mm.clear();
	endtask
	// mapped registers, dual ram, master restrictions
	task automatic t_ram();
		mm.put(0, 32'h000000BF, 0, 0);
		go();
		chk("regs_tgt", MMDEC_T_REGS, tg(0));
		mm.put(0, 32'h000000C0, 0, 0);
		mm.put(5, 32'h000100C0, 0, 0);
		mm.put(6, 32'h00090000, 0, 0);
		go();
		chk("dual_access_ram_tgt", MMDEC_T_DUAL_ACCESS_RAM, tg(0));
		chk("lcd_refused", 1, refused_r[5]);
		chk("usb_single_access_ram", MMDEC_T_SINGLE_ACCESS_RAM, tg(6));
		chk("usb_single_access_ram_addr", 32'h00010000, local_addr_r[167:144]);
		mm.put(0, 32'h0000E000, 0, 0);
		go();
		chk("dual_access_ram_blk7", 7, block_r[5:0]);
		mm.clear();
	endtask
	// block collisions and dma io access
	task automatic t_arb();
		mm.put(1, 32'h00092000, 0, 0);
		mm.put(2, 32'h00092000, 1, 0);
		go();
		chk("single_access_ram_win_lose", 2'b01, {refused_r[2], grant_r[1]} ^ 2'b10);
		mm.put(1, 32'h00012000, 0, 0);
		mm.put(2, 32'h00012000, 1, 0);
		mm.put(3, 32'h00001A00, 0, 1);
		mm.put(4, 32'h01300000, 0, 0);
		go();
		chk("dma_ext0_addr", 32'h00350000, local_addr_r[119:96]);
		chk("dma_ext0_cs", 5'h1E, external_chip_select_n_r);
		chk("dual_access_ram_both", 2'b11, grant_r[2:1]);
		chk("dma_io", MMDEC_T_IO, tg(3));
		mm.clear();
	endtask
	// verdict
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// watchdog well beyond the few dozen cycles of the sequence
	initial begin
		repeat (5000) @(posedge sys_clk);
		fail_count++;
		test_done();
	end
	initial begin
		rstn = 1'b0;
		rom_disable_wr = 1'b0;
		rom_disable_val = 1'b0;
		soft_reset = 1'b0;
		sdram_dual_cs = 1'b0;
		repeat (10) @(negedge sys_clk);
		rstn = 1'b1;
		t_rom();
		t_romdis();
		t_ext();
		t_ram();
		t_arb();
		test_done();
	end
endmodule
